// >>> rtl/lec_pkg.sv
// Package for the lane and gain control bank: offsets, field positions, reset values and carriers.
// Assumes a simple byte-wide register port from the serial management interface on the same clock.
package lec_pkg;

   // Register offsets.
   localparam logic [7:0] LEC_LANE_CTRL_OFF   = 8'h13;
   localparam logic [7:0] LEC_RX_GAIN_OFF     = 8'h20;
   localparam logic [7:0] LEC_UP_GAIN_OFF     = 8'h21;

   // Lane control field positions.
   localparam int LEC_SNOOP_OFF_BIT  = 7;
   localparam int LEC_RSVD_BIT       = 6;
   localparam int LEC_ROUTE_HI       = 5;
   localparam int LEC_ROUTE_LO       = 4;
   localparam int LEC_LANE_OFF_HI    = 3;

   // Gain field positions.
   localparam int LEC_RX1_LO         = 0;
   localparam int LEC_RX2_LO         = 4;
   localparam int LEC_GAIN_W         = 4;

   // Position of the gain source select in the general control register.
   localparam int LEC_GAIN_SRC_BIT   = 4;

   // Writable mask of the lane control register; bit 6 is reserved.
   localparam logic [7:0] LEC_LANE_WMASK = 8'hBF;
   localparam logic [7:0] LEC_UP_WMASK   = 8'h0F;

   // Reset values.
   localparam logic [7:0] LEC_LANE_CTRL_RST = 8'h00;
   localparam logic [7:0] LEC_RX_GAIN_RST   = 8'h00;
   localparam logic [7:0] LEC_UP_GAIN_RST   = 8'h00;

   // Sideband route force encodings.
   typedef enum logic [1:0] {
      LEC_ROUTE_AUTO  = 2'b00,
      LEC_ROUTE_NORM  = 2'b01,
      LEC_ROUTE_SWAP  = 2'b10,
      LEC_ROUTE_OPEN  = 2'b11
   } lec_route_e;

   // Register port request.
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } lec_req_s;

   // Sideband switch controls: each bit closes one path.
   typedef struct packed {
      logic auxn_to_sb1;
      logic auxp_to_sb2;
      logic auxn_to_sb2;
      logic auxp_to_sb1;
   } lec_sb_s;

endpackage : lec_pkg

// >>> rtl/lec_sync2.sv
// Two flip-flop synchroniser for a bus of pin levels.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/1ps
module lec_sync2
   import lec_pkg::*;
#(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end

endmodule : lec_sync2

// >>> rtl/lec_regs.sv
// Lane enable, sideband route and receiver gain control bank.
// Assumes a byte-wide register port on clk and strap, select and snoop inputs from other logic or pins.
`timescale 1ns/1ps

// Operation
// - Bit 7 set stops AUX snooping; clear enables it; resets clear.
// - Route 00 follows function and orientation select; 11 leaves AUX open.
// - Route 01 connects AUX negative to sideband 1, positive to sideband 2.
// - Route 10 connects AUX negative to sideband 2, positive to sideband 1.
// - Routes 01 and 10 pass AUX regardless of function and orientation select.
// - With snooping off, bits 3:0 directly enable or disable lanes 3 to 0.
// - With snooping on, lane bits are stored but do not affect lanes.
// - Lane bit 0 enables, 1 disables; all reset to 0.
// - First receiver gain sits at bits 3:0 of the gain register.
// - Second receiver gain sits at bits 7:4 of the gain register.
// - Gain source clear: gain fields read back sampled strap values.
// - Gain source set: written gain fields drive receiver gains.
// - Gain register at offset 0x20 resets to zero.
// - Lane control register at offset 0x13 resets to zero.
// - With snooping on, counts 1, 2 and 4 enable that many low lanes; any other count enables none.
// - Gain source control bit 4 selects strap or register gains.
module lec_regs
   import lec_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Register port
   input  wire lec_req_s   req,
   input  wire logic       req_valid,
   output logic      [7:0] rdata,
   output logic            addr_hit,
   // General control register value from the neighbouring bank
   input  wire logic [7:0] gen_ctrl,
   // Selects and straps
   input  wire logic       function_select_video_bit,
   input  wire logic       orientation_select,
   input  wire logic [1:0] usb_gain_strap_pins,
   input  wire logic [1:0] up_gain_strap_pins,
   // Snooped lane count
   input  wire logic [4:0] snoop_lane_count,
   // Block controls
   output logic      [3:0] video_lane_on,
   output lec_sb_s         sideband_sw,
   output logic      [3:0] rx1_gain_level,
   output logic      [3:0] rx2_gain_level,
   output logic      [3:0] up_gain_level
);

   logic [7:0] lane_ctrl_reg;
   logic [7:0] rx_gain_reg;
   logic [7:0] up_gain_reg;
   logic [1:0] strap_rx_q;
   logic [1:0] strap_up_q;
   logic [3:0] rx1_next;
   logic [3:0] rx2_next;
   logic [3:0] up_next;
   logic [3:0] lane_on_next;
   lec_sb_s    sb_next;

   // Strap pins come from outside the clock domain.
   lec_sync2 #(.W(2)) u_sync_rx (
      .clk (clk),
      .rst (rst),
      .d   (usb_gain_strap_pins),
      .q   (strap_rx_q)
   );

   lec_sync2 #(.W(2)) u_sync_up (
      .clk (clk),
      .rst (rst),
      .d   (up_gain_strap_pins),
      .q   (strap_up_q)
   );

   // Decode.
   wire        wr_lane     = req_valid & req.wr & (req.addr == LEC_LANE_CTRL_OFF);
   wire        wr_rx       = req_valid & req.wr & (req.addr == LEC_RX_GAIN_OFF);
   wire        wr_up       = req_valid & req.wr & (req.addr == LEC_UP_GAIN_OFF);
   wire        gain_from_registers = gen_ctrl[LEC_GAIN_SRC_BIT];
   wire        snoop_off   = lane_ctrl_reg[LEC_SNOOP_OFF_BIT];
   wire [1:0]  route_raw   = lane_ctrl_reg[LEC_ROUTE_HI:LEC_ROUTE_LO];
   wire [3:0]  lane_off    = lane_ctrl_reg[LEC_LANE_OFF_HI:0];
   wire [3:0]  strap_gain  = {2'b00, strap_rx_q};
   wire [3:0]  strap_upg   = {2'b00, strap_up_q};

   assign addr_hit = (req.addr == LEC_LANE_CTRL_OFF) | (req.addr == LEC_RX_GAIN_OFF) |
                     (req.addr == LEC_UP_GAIN_OFF);

   // Gain fields: straps while the source is clear, software values when set.
   // While straps rule, the register keeps tracking them, so a later switch starts from the strap value.
   assign rx1_next = !gain_from_registers ? strap_gain :
                     wr_rx ? req.wdata[LEC_RX1_LO +: LEC_GAIN_W] :
                     rx_gain_reg[LEC_RX1_LO +: LEC_GAIN_W];
   assign rx2_next = !gain_from_registers ? strap_gain :
                     wr_rx ? req.wdata[LEC_RX2_LO +: LEC_GAIN_W] :
                     rx_gain_reg[LEC_RX2_LO +: LEC_GAIN_W];
   assign up_next  = !gain_from_registers ? strap_upg :
                     wr_up ? (req.wdata[3:0] & LEC_UP_WMASK[3:0]) : up_gain_reg[3:0];

   // Lane enables: snooped count when snooping, disable bits otherwise.
   always_comb begin
      lane_on_next = 4'h0;
      if (snoop_off) begin
         lane_on_next = ~lane_off;
      end else begin
         case (snoop_lane_count)
            5'h01:   lane_on_next = 4'h1;
            5'h02:   lane_on_next = 4'h3;
            5'h04:   lane_on_next = 4'hF;
            default: lane_on_next = 4'h0;
         endcase
      end
   end

   // Sideband switch matrix.
   always_comb begin
      sb_next = '0;
      case (lec_route_e'(route_raw))
         LEC_ROUTE_AUTO: begin
            if (function_select_video_bit) begin
               sb_next.auxn_to_sb1 = ~orientation_select;
               sb_next.auxp_to_sb2 = ~orientation_select;
               sb_next.auxn_to_sb2 = orientation_select;
               sb_next.auxp_to_sb1 = orientation_select;
            end
         end
         LEC_ROUTE_NORM: begin
            sb_next.auxn_to_sb1 = 1'b1;
            sb_next.auxp_to_sb2 = 1'b1;
         end
         LEC_ROUTE_SWAP: begin
            sb_next.auxn_to_sb2 = 1'b1;
            sb_next.auxp_to_sb1 = 1'b1;
         end
         LEC_ROUTE_OPEN: sb_next = '0;
         default:        sb_next = '0;
      endcase
   end

   // Registers.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lane_ctrl_reg <= LEC_LANE_CTRL_RST;
         rx_gain_reg   <= LEC_RX_GAIN_RST;
         up_gain_reg   <= LEC_UP_GAIN_RST;
      end else begin
         if (wr_lane) begin
            lane_ctrl_reg <= req.wdata & LEC_LANE_WMASK;
         end
         rx_gain_reg <= {rx2_next, rx1_next};
         up_gain_reg <= {4'h0, up_next};
      end
   end

   // Outputs held in flip-flops.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         video_lane_on  <= 4'h0;
         sideband_sw    <= '0;
         rx1_gain_level <= 4'h0;
         rx2_gain_level <= 4'h0;
         up_gain_level  <= 4'h0;
      end else begin
         video_lane_on  <= lane_on_next;
         sideband_sw    <= sb_next;
         rx1_gain_level <= rx_gain_reg[LEC_RX1_LO +: LEC_GAIN_W];
         rx2_gain_level <= rx_gain_reg[LEC_RX2_LO +: LEC_GAIN_W];
         up_gain_level  <= up_gain_reg[3:0];
      end
   end

   // Read mux; unmapped offsets read zero.
   always_comb begin
      rdata = 8'h00;
      case (req.addr)
         LEC_LANE_CTRL_OFF: rdata = lane_ctrl_reg & LEC_LANE_WMASK;
         LEC_RX_GAIN_OFF:   rdata = rx_gain_reg;
         LEC_UP_GAIN_OFF:   rdata = up_gain_reg;
         default:           rdata = 8'h00;
      endcase
   end

endmodule : lec_regs

// >>> verification/lec_regs_sva.sv
// Checker for lec_regs: readback, lane enables, sideband paths and receiver gains.
// Assumes it is bound into lec_regs and watches its ports by name.
`timescale 1ns/1ps
module lec_regs_sva
   import lec_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst,
   input wire lec_req_s   req,
   input wire logic       req_valid,
   input wire logic [7:0] rdata,
   input wire logic [7:0] gen_ctrl,
   input wire logic       function_select_video_bit,
   input wire logic       orientation_select,
   input wire logic [1:0] usb_gain_strap_pins,
   input wire logic [4:0] snoop_lane_count,
   input wire logic [3:0] video_lane_on,
   input wire lec_sb_s    sideband_sw,
   input wire logic [3:0] rx1_gain_level,
   input wire logic [3:0] rx2_gain_level
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire w13 = req_valid && req.wr && req.addr == LEC_LANE_CTRL_OFF;
   wire w20 = req_valid && req.wr && req.addr == LEC_RX_GAIN_OFF && gen_ctrl[LEC_GAIN_SRC_BIT];
   // Outputs are registered behind the register, so a write shows two edges later.
   property p_lane_off;
      (w13 && req.wdata[LEC_SNOOP_OFF_BIT]) ##1 !w13 |=> video_lane_on == ~$past(req.wdata[3:0], 2);
   endproperty
   a_lane_off: assert property (p_lane_off) else $error("lane enables wrong");
   property p_snoop;
      (w13 && !req.wdata[LEC_SNOOP_OFF_BIT]) ##1 !w13 |=> video_lane_on == ($past(snoop_lane_count) == 5'h01 ? 4'h1 :
         $past(snoop_lane_count) == 5'h02 ? 4'h3 : $past(snoop_lane_count) == 5'h04 ? 4'hF : 4'h0);
   endproperty
   a_snoop: assert property (p_snoop) else $error("snooped lanes wrong");
   property p_back; w13 ##1 (req.addr == LEC_LANE_CTRL_OFF) |-> rdata == ($past(req.wdata) & LEC_LANE_WMASK); endproperty
   a_back: assert property (p_back) else $error("lane readback wrong");
   property p_rsvd; req.addr == LEC_LANE_CTRL_OFF |-> !rdata[LEC_RSVD_BIT]; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
   property p_force;
      (w13 && req.wdata[5:4] != 2'b00) ##1 !w13 |=> sideband_sw == ($past(req.wdata[5:4], 2) == 2'b01 ? 4'hC :
         $past(req.wdata[5:4], 2) == 2'b10 ? 4'h3 : 4'h0);
   endproperty
   a_force: assert property (p_force) else $error("forced route wrong");
   property p_auto;
      (w13 && req.wdata[5:4] == 2'b00) ##1 !w13 |=> sideband_sw == (!$past(function_select_video_bit) ? 4'h0 :
         $past(orientation_select) ? 4'h3 : 4'hC);
   endproperty
   a_auto: assert property (p_auto) else $error("select route wrong");
   property p_gain; w20 ##1 (!w20 && gen_ctrl[LEC_GAIN_SRC_BIT]) |=> {rx2_gain_level, rx1_gain_level} == $past(req.wdata, 2); endproperty
   a_gain: assert property (p_gain) else $error("written gain wrong");
   property p_strap;
      (!gen_ctrl[LEC_GAIN_SRC_BIT] && $stable(usb_gain_strap_pins))[*6] |=> {rx2_gain_level, rx1_gain_level} ==
         {2'b00, $past(usb_gain_strap_pins), 2'b00, $past(usb_gain_strap_pins)};
   endproperty
   a_strap: assert property (p_strap) else $error("strap gain wrong");
endmodule : lec_regs_sva

// >>> verification/lec_regs_bench.sv
// Bench for lec_regs: reset, then hand-written scenarios on registers, selects, straps and snoop count.
// Assumes lec_pkg; the checker is bound below the module.
`timescale 1ns/1ps
module lec_regs_bench;
   import lec_pkg::*;
   logic       clk = 1'b0, rst = 1'b1, req_valid = 1'b0, function_select_video_bit = 1'b0;
   logic       orientation_select = 1'b0, addr_hit;
   logic [1:0] usb_gain_strap_pins = 2'b00, up_gain_strap_pins = 2'b00;
   logic [3:0] video_lane_on, rx1_gain_level, rx2_gain_level, up_gain_level;
   logic [4:0] snoop_lane_count = 5'h00;
   logic [7:0] rdata, gen_ctrl = 8'h00;
   lec_req_s   req = '0;
   lec_sb_s    sideband_sw;
   int         failures = 0, samples_checked = 0;
   always #10 clk = ~clk;
   lec_regs dut (
      .clk                       (clk),
      .rst                       (rst),
      .req                       (req),
      .req_valid                 (req_valid),
      .rdata                     (rdata),
      .addr_hit                  (addr_hit),
      .gen_ctrl                  (gen_ctrl),
      .function_select_video_bit (function_select_video_bit),
      .orientation_select        (orientation_select),
      .usb_gain_strap_pins       (usb_gain_strap_pins),
      .up_gain_strap_pins        (up_gain_strap_pins),
      .snoop_lane_count          (snoop_lane_count),
      .video_lane_on             (video_lane_on),
      .sideband_sw               (sideband_sw),
      .rx1_gain_level            (rx1_gain_level),
      .rx2_gain_level            (rx2_gain_level),
      .up_gain_level             (up_gain_level)
   );
   task automatic chk(input string n, input logic [7:0] s, e);
      samples_checked++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // Waiting two cycles after the strobe lets the twice-registered outputs settle before judging.
   task automatic access(input logic w, input logic [7:0] a, d, e);
      @(negedge clk);
      req = '{w, a, d};
      req_valid = w;
      @(negedge clk);
      req_valid = 1'b0;
      req.wr = 1'b0;
      repeat (2) @(negedge clk);
      chk("rdata", rdata, e);
   endtask : access
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : give_verdict
   task automatic t_reset;
      access(1'b0, LEC_LANE_CTRL_OFF, 8'h00, 8'h00);
      access(1'b0, LEC_RX_GAIN_OFF, 8'h00, 8'h00);
      access(1'b1, 8'h30, 8'h55, 8'h00);
      chk("hit", addr_hit, 8'h00);
   endtask : t_reset
   task automatic t_lanes;
      snoop_lane_count = 5'h02;
      access(1'b1, LEC_LANE_CTRL_OFF, 8'hCA, 8'h8A);
      chk("lanes", video_lane_on, 8'h05);
      access(1'b1, LEC_LANE_CTRL_OFF, 8'h4F, 8'h0F);
      chk("lanes", video_lane_on, 8'h03);
      snoop_lane_count = 5'h04;
      access(1'b0, LEC_LANE_CTRL_OFF, 8'h00, 8'h0F);
      chk("lanes", video_lane_on, 8'h0F);
      snoop_lane_count = 5'h01;
      access(1'b0, LEC_LANE_CTRL_OFF, 8'h00, 8'h0F);
      chk("lanes", video_lane_on, 8'h01);
      snoop_lane_count = 5'h03;
      access(1'b0, LEC_LANE_CTRL_OFF, 8'h00, 8'h0F);
      chk("lanes", video_lane_on, 8'h00);
   endtask : t_lanes
   task automatic t_route;
      logic [3:0] e;
      for (int i = 0; i < 16; i++) begin
         {function_select_video_bit, orientation_select} = i[3:2];
         e = i[1:0] == 2'd1 ? 4'hC : i[1:0] == 2'd2 ? 4'h3 : (i[1:0] == 2'd3 || !i[3]) ? 4'h0 : i[2] ? 4'h3 : 4'hC;
         access(1'b1, LEC_LANE_CTRL_OFF, {2'b10, i[1:0], 4'h0}, {2'b10, i[1:0], 4'h0});
         chk("sideband", sideband_sw, e);
      end
   endtask : t_route
   task automatic t_gain;
      gen_ctrl = 8'h10;
      access(1'b1, LEC_RX_GAIN_OFF, 8'hA5, 8'hA5);
      chk("rx1", rx1_gain_level, 8'h05);
      chk("rx2", rx2_gain_level, 8'h0A);
      access(1'b1, LEC_UP_GAIN_OFF, 8'hF7, 8'h07);
      chk("up", up_gain_level, 8'h07);
      gen_ctrl = 8'h00;
      usb_gain_strap_pins = 2'b10;
      up_gain_strap_pins = 2'b01;
      access(1'b1, LEC_RX_GAIN_OFF, 8'h99, 8'h22);
      chk("rx1", rx1_gain_level, 8'h02);
      chk("rx2", rx2_gain_level, 8'h02);
      access(1'b0, LEC_UP_GAIN_OFF, 8'h00, 8'h01);
      chk("up", up_gain_level, 8'h01);
      chk("hit", addr_hit, 8'h01);
   endtask : t_gain
   // A reset in mid-run must clear registers that hold non-zero values by now.
   task automatic t_midreset;
      req.addr = LEC_LANE_CTRL_OFF;
      @(negedge clk);
      rst = 1'b1;
      @(negedge clk);
      chk("lane rst", rdata, 8'h00);
      chk("lanes rst", video_lane_on, 8'h00);
      req.addr = LEC_RX_GAIN_OFF;
      @(negedge clk);
      chk("rx rst", rdata, 8'h00);
      chk("rx1 rst", rx1_gain_level, 8'h00);
      rst = 1'b0;
      access(1'b0, LEC_LANE_CTRL_OFF, 8'h00, 8'h00);
   endtask : t_midreset
   initial begin
      repeat (12) @(negedge clk);
      rst = 1'b0;
      t_reset;
      t_lanes;
      t_route;
      t_gain;
      t_midreset;
      give_verdict;
   end
   // The scenarios need about 130 cycles; the watchdog allows far more.
   initial begin
      #40000;
      failures++;
      give_verdict;
   end
endmodule : lec_regs_bench
bind lec_regs lec_regs_sva u_sva (
   .clk                       (clk),
   .rst                       (rst),
   .req                       (req),
   .req_valid                 (req_valid),
   .rdata                     (rdata),
   .gen_ctrl                  (gen_ctrl),
   .function_select_video_bit (function_select_video_bit),
   .orientation_select        (orientation_select),
   .usb_gain_strap_pins       (usb_gain_strap_pins),
   .snoop_lane_count          (snoop_lane_count),
   .video_lane_on             (video_lane_on),
   .sideband_sw               (sideband_sw),
   .rx1_gain_level            (rx1_gain_level),
   .rx2_gain_level            (rx2_gain_level)
);
